// ==== logic/tes_pkg.sv ====
package tes_pkg;

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [6:0] IDX_LEVEL106 = 7'h44;
   localparam logic [6:0] IDX_TYPE106 = 7'h45;
   localparam logic [6:0] IDX_STYLE106 = 7'h46;
   localparam logic [6:0] IDX_LENGTH106 = 7'h47;
   localparam logic [6:0] IDX_LEVEL212 = 7'h48;
   localparam logic [6:0] IDX_TYPE212 = 7'h49;
   localparam logic [6:0] IDX_STYLE212 = 7'h4a;
   localparam logic [6:0] IDX_LENGTH212 = 7'h4b;
   localparam logic [6:0] IDX_STATUS = 7'h50;
   localparam int NUM_CFG = 8;
   localparam logic [2:0] SET212_BASE = 3'h4;
   localparam logic [2:0] OFS_LEVEL = 3'h0;
   localparam logic [2:0] OFS_TYPE = 3'h1;
   localparam logic [2:0] OFS_STYLE = 3'h2;
   localparam logic [2:0] OFS_LENGTH = 3'h3;

   // -----------------------------------------------------------------
   // field layout, writable bits and reset values
   // -----------------------------------------------------------------
   localparam int FALL_LSB = 4;
   localparam int LEN_DOUBLE_BIT = 7;
   localparam logic [7:0] MASK_LEVEL = 8'hff;
   localparam logic [7:0] MASK_TYPE = 8'hff;
   localparam logic [7:0] MASK_STYLE = 8'h77;
   localparam logic [7:0] MASK_LENGTH = 8'h9f;
   localparam logic [7:0] RST_CFG = 8'h00;

   // -----------------------------------------------------------------
   // edge shape codes and levels
   // -----------------------------------------------------------------
   localparam logic [3:0] CODE_FW1 = 4'h1;
   localparam logic [3:0] CODE_FW2 = 4'h2;
   localparam logic [3:0] CODE_FW3 = 4'h3;
   localparam logic [3:0] CODE_LUT_PLAIN = 4'h4;
   localparam logic [3:0] CODE_LUT_CORR = 4'h5;
   localparam logic [3:0] CODE_LUT_NOCORR = 4'h6;
   localparam logic [7:0] FULL_AMPL = 8'hff;
   localparam logic [7:0] KNEE_LO = 8'h55;
   localparam logic [7:0] KNEE_MID = 8'h80;
   localparam logic [7:0] KNEE_HI = 8'haa;

   // four shape tables of eight progress points, last point 0xff, first point 0x04 to 0x20
   localparam logic [3:0][7:0][7:0] SHAPE_LUT = {
      {8'hff, 8'hf8, 8'he8, 8'hd0, 8'hb0, 8'h88, 8'h58, 8'h20},
      {8'hff, 8'hd8, 8'hb0, 8'h88, 8'h60, 8'h40, 8'h20, 8'h08},
      {8'hff, 8'hf0, 8'hd0, 8'ha0, 8'h60, 8'h30, 8'h10, 8'h04},
      {8'hff, 8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20}
   };

   typedef enum logic [1:0] {PH_HIGH, PH_FALL, PH_LOW, PH_RISE}
      tes_phase_type;

endpackage

// ==== logic/tes_shaper.sv ====
module tes_shaper (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   // avalon-mm slave
   input wire logic [8:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   // modulation request and supply, same clock domain
   input wire logic MOD_IN,
   input wire logic RATE212_IN,
   input wire logic [7:0] SUPPLY_LEVEL_IN,
   // shaped envelope
   output logic [7:0] AMPL_OUT,
   output logic EDGE_BUSY_OUT
);

   typedef struct packed {
      logic [tes_pkg::NUM_CFG-1:0][7:0] cfg;
      logic waitreq;
      logic [31:0] rdata;
      tes_pkg::tes_phase_type phase;
      logic [4:0] step;
      logic hold;
      logic [3:0] code;
      logic [2:0] sel;
      logic [4:0] cnt;
      logic dbl;
      logic [7:0] lo;
      logic set212;
      logic [7:0] ampl;
      logic busy;
   } tes_state_type;

   tes_state_type s;
   tes_state_type next_s;

   // -----------------------------------------------------------------
   // shaping helpers
   // -----------------------------------------------------------------

   // bend a linear progress value; tc sets how hard the bend is
   function automatic logic [7:0] bend(input logic [7:0] x,
                                       input logic [2:0] tc);
      logic [11:0] t;
      t = 12'(x) + ((12'(x) * 12'(tc)) >> 4);
      bend = (t > 12'(tes_pkg::FULL_AMPL)) ? tes_pkg::FULL_AMPL : t[7:0];
   endfunction

   // progress 0..ff of a given state within an edge
   function automatic logic [7:0] progress(input logic [3:0] code,
                                           input logic [2:0] sel,
                                           input logic [4:0] cnt,
                                           input logic [4:0] step);
      logic [12:0] lin;
      logic [7:0] frac;
      logic [7:0] f;
      lin = (13'(step) * 13'(tes_pkg::FULL_AMPL)) / 13'(cnt);
      frac = lin[7:0];
      f = frac;
      case (code)
         tes_pkg::CODE_FW1: f = frac;
         tes_pkg::CODE_FW2: begin
            // two segments joined at mid swing
            if (frac < tes_pkg::KNEE_MID) begin
               f = bend(frac, sel);
            end else begin
               f = frac;
            end
         end
         tes_pkg::CODE_FW3: begin
            // outer segments bent, middle segment straight
            if (frac < tes_pkg::KNEE_LO) begin
               f = bend(frac, sel);
            end else if (frac < tes_pkg::KNEE_HI) begin
               f = frac;
            end else begin
               f = tes_pkg::FULL_AMPL - bend(tes_pkg::FULL_AMPL - frac, sel);
            end
         end
         tes_pkg::CODE_LUT_PLAIN, tes_pkg::CODE_LUT_CORR,
         tes_pkg::CODE_LUT_NOCORR: begin
            // the top style bit is not a table index and is ignored
            f = tes_pkg::SHAPE_LUT[sel[1:0]][frac[7:5]];
         end
         default: f = frac;
      endcase
      // last state always lands exactly on the target level
      progress = (step == cnt) ? tes_pkg::FULL_AMPL : f;
   endfunction

   // floor level, optionally following the transmitter supply
   function automatic logic [7:0] adapt(input logic [3:0] code,
                                        input logic [7:0] lvl,
                                        input logic [7:0] sup);
      logic [15:0] p;
      logic [8:0] t;
      p = 16'(lvl) * 16'(sup);
      t = 9'(p[15:8]) + 9'((tes_pkg::FULL_AMPL - sup) >> 3);
      case (code)
         tes_pkg::CODE_LUT_CORR: begin
            adapt = t[8] ? tes_pkg::FULL_AMPL : t[7:0];
         end
         tes_pkg::CODE_LUT_NOCORR: adapt = p[15:8];
         default: adapt = lvl;
      endcase
   endfunction

   // amplitude of a state, falling from full or rising from floor
   function automatic logic [7:0] level(input logic [7:0] f,
                                        input logic [7:0] lo,
                                        input logic falling);
      logic [15:0] d;
      d = (16'(tes_pkg::FULL_AMPL - lo) * 16'(f)) / 16'(tes_pkg::FULL_AMPL);
      level = falling ? tes_pkg::FULL_AMPL - d[7:0] : lo + d[7:0];
   endfunction

   function automatic logic shapeable(input logic [3:0] code);
      shapeable = (code >= tes_pkg::CODE_FW1) &&
                  (code <= tes_pkg::CODE_LUT_NOCORR);
   endfunction

   // -----------------------------------------------------------------
   // register decode
   // -----------------------------------------------------------------
   logic [6:0] idx;
   logic hit;
   logic [2:0] cfg_ofs;
   logic [7:0] wmask;
   logic [31:0] read_word;

   always_comb begin
      idx = AVS_ADDRESS_IN[8:2];
      // slot 0 must be the 106 level register so the set base lines up
      cfg_ofs = 3'(idx - tes_pkg::IDX_LEVEL106);
      hit = (AVS_ADDRESS_IN[1:0] == 2'h0) &&
            (idx >= tes_pkg::IDX_LEVEL106) &&
            (idx <= tes_pkg::IDX_LENGTH212);
      case (cfg_ofs[1:0])
         tes_pkg::OFS_LEVEL[1:0]: wmask = tes_pkg::MASK_LEVEL;
         tes_pkg::OFS_TYPE[1:0]: wmask = tes_pkg::MASK_TYPE;
         tes_pkg::OFS_STYLE[1:0]: wmask = tes_pkg::MASK_STYLE;
         default: wmask = tes_pkg::MASK_LENGTH;
      endcase
      read_word = 32'h0;
      if (hit) begin
         read_word = {24'h0, s.cfg[cfg_ofs]};
      end else if ((AVS_ADDRESS_IN[1:0] == 2'h0) &&
                   (idx == tes_pkg::IDX_STATUS)) begin
         read_word = {20'h0, s.set212, s.busy, s.phase, s.ampl};
      end
   end

   // -----------------------------------------------------------------
   // parameter set selection
   // -----------------------------------------------------------------
   logic [2:0] base;
   logic [7:0] sel_level;
   logic [7:0] sel_type;
   logic [7:0] sel_style;
   logic [7:0] sel_length;
   logic [3:0] fall_code;
   logic [3:0] rise_code;
   logic [7:0] fall_lo;
   logic [7:0] rise_lo;

   always_comb begin
      base = RATE212_IN ? tes_pkg::SET212_BASE : 3'h0;
      sel_level = s.cfg[base + tes_pkg::OFS_LEVEL];
      sel_type = s.cfg[base + tes_pkg::OFS_TYPE];
      sel_style = s.cfg[base + tes_pkg::OFS_STYLE];
      sel_length = s.cfg[base + tes_pkg::OFS_LENGTH];
      fall_code = sel_type[tes_pkg::FALL_LSB +: 4];
      rise_code = sel_type[3:0];
      fall_lo = adapt(fall_code, sel_level, SUPPLY_LEVEL_IN);
      rise_lo = adapt(rise_code, sel_level, SUPPLY_LEVEL_IN);
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_s = s;

      // one wait cycle per access; write lands when wait is low
      if (s.waitreq) begin
         if (AVS_READ_IN || AVS_WRITE_IN) begin
            next_s.waitreq = 1'b0;
            next_s.rdata = read_word;
         end
      end else begin
         next_s.waitreq = 1'b1;
         if (AVS_WRITE_IN && hit && AVS_BYTEENABLE_IN[0]) begin
            // reserved bits are dropped and read back as zero
            next_s.cfg[cfg_ofs] = AVS_WRITEDATA_IN[7:0] & wmask;
         end
      end

      case (s.phase)
         tes_pkg::PH_HIGH: begin
            next_s.ampl = tes_pkg::FULL_AMPL;
            next_s.busy = 1'b0;
            if (MOD_IN) begin
               // latch the whole edge so a mid-edge write cannot tear it
               next_s.set212 = RATE212_IN;
               next_s.code = fall_code;
               next_s.sel = sel_style[tes_pkg::FALL_LSB +: 3];
               next_s.cnt = sel_length[4:0];
               next_s.dbl = sel_length[tes_pkg::LEN_DOUBLE_BIT];
               next_s.lo = fall_lo;
               if (shapeable(fall_code) && (sel_length[4:0] != 5'h0)) begin
                  next_s.phase = tes_pkg::PH_FALL;
                  next_s.busy = 1'b1;
                  next_s.step = 5'h1;
                  next_s.hold = sel_length[tes_pkg::LEN_DOUBLE_BIT];
                  next_s.ampl = level(progress(fall_code,
                     sel_style[tes_pkg::FALL_LSB +: 3], sel_length[4:0],
                     5'h1), fall_lo, 1'b1);
               end else begin
                  // reserved code or no states: a plain hard step
                  next_s.phase = tes_pkg::PH_LOW;
                  next_s.ampl = fall_lo;
               end
            end
         end
         tes_pkg::PH_LOW: begin
            next_s.busy = 1'b0;
            next_s.lo = adapt(s.code, s.cfg[(s.set212 ?
               tes_pkg::SET212_BASE : 3'h0) + tes_pkg::OFS_LEVEL],
               SUPPLY_LEVEL_IN);
            next_s.ampl = next_s.lo;
            if (!MOD_IN) begin
               next_s.set212 = RATE212_IN;
               next_s.code = rise_code;
               next_s.sel = sel_style[2:0];
               next_s.cnt = sel_length[4:0];
               next_s.dbl = sel_length[tes_pkg::LEN_DOUBLE_BIT];
               next_s.lo = rise_lo;
               if (shapeable(rise_code) && (sel_length[4:0] != 5'h0)) begin
                  next_s.phase = tes_pkg::PH_RISE;
                  next_s.busy = 1'b1;
                  next_s.step = 5'h1;
                  next_s.hold = sel_length[tes_pkg::LEN_DOUBLE_BIT];
                  next_s.ampl = level(progress(rise_code, sel_style[2:0],
                     sel_length[4:0], 5'h1), rise_lo, 1'b0);
               end else begin
                  next_s.phase = tes_pkg::PH_HIGH;
                  next_s.ampl = tes_pkg::FULL_AMPL;
               end
            end
         end
         tes_pkg::PH_FALL, tes_pkg::PH_RISE: begin
            // an edge always runs to its end; the request is seen after
            if (s.hold) begin
               next_s.hold = 1'b0;
            end else if (s.step == s.cnt) begin
               next_s.busy = 1'b0;
               next_s.phase = (s.phase == tes_pkg::PH_FALL) ?
                  tes_pkg::PH_LOW : tes_pkg::PH_HIGH;
            end else begin
               next_s.step = s.step + 5'h1;
               next_s.hold = s.dbl;
               next_s.ampl = level(progress(s.code, s.sel, s.cnt,
                  next_s.step), s.lo, s.phase == tes_pkg::PH_FALL);
            end
         end
         default: begin
            next_s.phase = tes_pkg::PH_HIGH;
            next_s.busy = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         s <= '0;
         s.cfg <= {tes_pkg::NUM_CFG{tes_pkg::RST_CFG}};
         s.waitreq <= 1'b1;
         s.phase <= tes_pkg::PH_HIGH;
         s.ampl <= tes_pkg::FULL_AMPL;
      end else begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign AVS_READDATA_OUT = s.rdata;
   assign AVS_WAITREQUEST_OUT = s.waitreq;
   assign AMPL_OUT = s.ampl;
   assign EDGE_BUSY_OUT = s.busy;

endmodule

// ==== test/tes_shaper_checker.sv ====
module tes_shaper_checker (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   // register bus
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT,
   // envelope
   input wire logic MOD_IN,
   input wire logic [7:0] AMPL_OUT,
   input wire logic EDGE_BUSY_OUT
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   a_wait_answer: assert property (
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      |=> !AVS_WAITREQUEST_OUT) else $error("access not answered");
   a_wait_single: assert property (
      !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("answer longer than one cycle");
   a_wait_cause: assert property (
      $fell(AVS_WAITREQUEST_OUT) |-> $past(AVS_READ_IN || AVS_WRITE_IN))
      else $error("answer without request");
   a_read_hold: assert property (
      AVS_WAITREQUEST_OUT |-> $stable(AVS_READDATA_OUT))
      else $error("read data moved outside an answer");
   // 31 states of two cycles each is the longest edge
   a_busy_bound: assert property (
      $rose(EDGE_BUSY_OUT) |-> ##[1:62] !EDGE_BUSY_OUT)
      else $error("edge runs too long");
   a_full_hold: assert property (
      AMPL_OUT == 8'hff && !EDGE_BUSY_OUT && !MOD_IN |=> AMPL_OUT == 8'hff)
      else $error("full carrier not held");
   a_fall_full: assert property (
      $rose(EDGE_BUSY_OUT) && $past(MOD_IN) |-> $past(AMPL_OUT) == 8'hff)
      else $error("falling edge not from full carrier");
   a_rise_floor: assert property (
      $rose(EDGE_BUSY_OUT) && !$past(MOD_IN)
      |-> AMPL_OUT >= $past(AMPL_OUT)) else $error("rise starts below floor");

   c_edge: cover property ($rose(EDGE_BUSY_OUT));
   c_write: cover property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT);
   c_read: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule

bind tes_shaper tes_shaper_checker u_chk (.SYS_CLK_IN, .RESETN_IN,
   .AVS_READ_IN, .AVS_WRITE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT,
   .MOD_IN, .AMPL_OUT, .EDGE_BUSY_OUT);

// ==== test/tes_shaper_tb.sv ====
module tes_shaper_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [8:0] addr = 9'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdata;
   logic waitreq;
   logic mod = 1'b0;
   logic rate = 1'b0;
   logic [7:0] supply = 8'h80;
   logic [7:0] ampl;
   logic busy;
   logic [31:0] got;
   int mismatches = 0;
   int checked = 0;
   // floor per shape code with level 80 and supply 80
   logic [7:0] flo [7] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h4f, 8'h40};
   logic [7:0] msk [4] = '{8'hff, 8'hff, 8'h77, 8'h9f};
   // inner states with level 80, style 21: code 2 fall, rise, code 4 fall, rise
   logic [7:0] tab [4][3] = '{'{8'hdd, 8'hb9, 8'ha0}, '{8'ha0, 8'hc2, 8'hdf},
      '{8'hf0, 8'hd0, 8'ha8}, '{8'h87, 8'haf, 8'he7}};
   int row = -1;

   always #2.5 clk = ~clk;

   tes_shaper DUT (.SYS_CLK_IN(clk), .RESETN_IN(rst_n),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
      .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
      .MOD_IN(mod), .RATE212_IN(rate), .SUPPLY_LEVEL_IN(supply),
      .AMPL_OUT(ampl), .EDGE_BUSY_OUT(busy));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // entered right after a rising edge; one idle edge ends it
   task automatic bus(input logic w, input logic [6:0] idx,
      input logic [7:0] d, input logic [3:0] b);
      addr <= {idx, 2'b00};
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      be <= b;
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   // n = 0 stands for a hard step with no busy phase
   task automatic edge_run(input logic m, input int n, input int dbl,
      input logic [7:0] lo, input logic full);
      logic [7:0] e;
      int f;
      mod <= m;
      for (int k = 1; k <= n; k++) begin
         f = k * 255 / n;
         e = m ? 8'(255 - (255 - lo) * f / 255) : 8'(lo + (255 - lo) * f / 255);
         for (int d = 0; d <= dbl; d++) begin
            @(posedge clk);
            #1;
            chk(busy, 1'b1);
            if (full || k == n) chk(ampl, e);
            if (row >= 0 && k < n) chk(ampl, tab[row][k-1]);
         end
      end
      @(posedge clk);
      #1;
      chk(busy, 1'b0);
      chk(ampl, m ? lo : 8'hff);
      @(posedge clk);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      #50000;
      mismatches++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 7'h44 + 7'(i), 8'h00, 4'h1);
         chk(got, 32'h0);
         bus(1'b1, 7'h44 + 7'(i), 8'hff, 4'h1);
         bus(1'b0, 7'h44 + 7'(i), 8'h00, 4'h1);
         chk(got, {24'h0, msk[i % 4]});
      end
      bus(1'b1, tes_pkg::IDX_LEVEL106, 8'h12, 4'h0);
      bus(1'b1, 7'h4c, 8'h5a, 4'h1);
      bus(1'b0, tes_pkg::IDX_LEVEL106, 8'h00, 4'h1);
      chk(got, 32'hff);
      bus(1'b0, 7'h4c, 8'h00, 4'h1);
      chk(got, 32'h0);
      bus(1'b0, tes_pkg::IDX_STATUS, 8'h00, 4'h1);
      chk(got, 32'hff);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, tes_pkg::IDX_LEVEL106, 8'h00, 4'h1);
      chk(got, 32'h0);
      $display("test registers done");
      bus(1'b1, tes_pkg::IDX_LEVEL106, 8'h40, 4'h1);
      bus(1'b1, tes_pkg::IDX_TYPE106, 8'h11, 4'h1);
      bus(1'b1, tes_pkg::IDX_LENGTH106, 8'h02, 4'h1);
      edge_run(1'b1, 2, 0, 8'h40, 1'b1);
      edge_run(1'b0, 2, 0, 8'h40, 1'b1);
      rate <= 1'b1;
      bus(1'b1, tes_pkg::IDX_TYPE212, 8'h11, 4'h1);
      bus(1'b1, tes_pkg::IDX_LENGTH212, 8'h83, 4'h1);
      edge_run(1'b1, 3, 1, 8'h00, 1'b1);
      bus(1'b0, tes_pkg::IDX_STATUS, 8'h00, 4'h1);
      chk(got, 32'h0a00);
      edge_run(1'b0, 3, 1, 8'h00, 1'b1);
      rate <= 1'b0;
      $display("test linear edges done");
      bus(1'b1, tes_pkg::IDX_LEVEL106, 8'h80, 4'h1);
      bus(1'b1, tes_pkg::IDX_LENGTH106, 8'h04, 4'h1);
      bus(1'b1, tes_pkg::IDX_STYLE106, 8'h21, 4'h1);
      for (int c = 1; c < 7; c++) begin
         bus(1'b1, tes_pkg::IDX_TYPE106, {4'(c), 4'(c)}, 4'h1);
         row = (c == 2) ? 0 : ((c == 4) ? 2 : -1);
         edge_run(1'b1, 4, 0, flo[c], c == 1);
         row = (row < 0) ? -1 : row + 1;
         edge_run(1'b0, 4, 0, flo[c], c == 1);
      end
      row = -1;
      $display("test shape codes done");
      bus(1'b1, tes_pkg::IDX_TYPE106, 8'h77, 4'h1);
      edge_run(1'b1, 0, 0, 8'h80, 1'b0);
      edge_run(1'b0, 0, 0, 8'h80, 1'b0);
      bus(1'b1, tes_pkg::IDX_TYPE106, 8'h11, 4'h1);
      bus(1'b1, tes_pkg::IDX_LENGTH106, 8'h00, 4'h1);
      edge_run(1'b1, 0, 0, 8'h80, 1'b0);
      edge_run(1'b0, 0, 0, 8'h80, 1'b0);
      $display("test reserved settings done");
      conclude();
   end
endmodule
